// File: verilog/eid_regs.svh
`ifndef EID_REGS_SVH
`define EID_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EID_OFS_PRIO 8'hF7
`define EID_OFS_CFG 8'hE4
`define EID_OFS_TIMER_CONTROL_REG 8'h88
`define EID_OFS_ISTAT 8'hD0
`define EID_OFS_ICLR 8'hD1
`define EID_OFS_IEN 8'hD2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EID_RST_PRIO 2'h0
`define EID_RST_CFG 8'h01
`define EID_RST_TRIG 2'h0
`define EID_RST_PEND 2'h0
`define EID_RST_IEN 2'h0
// ----------------------------------------
// Field positions in the timer control reg
// ----------------------------------------
`define EID_TIMER_CONTROL_REG_IT0 0
`define EID_TIMER_CONTROL_REG_IE0 1
`define EID_TIMER_CONTROL_REG_IT1 2
`define EID_TIMER_CONTROL_REG_IE1 3
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define EID_SYNC_STAGES 2
`endif

// File: verilog/eid_pkg.sv
// ----------------------------------------
// Shared types
// ----------------------------------------
package eid_pkg;
    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } eid_bus_t;
    // External input configuration layout
    typedef struct packed {
        logic pol1;
        logic [2:0] sel1;
        logic pol0;
        logic [2:0] sel0;
    } eid_cfg_t;
    // Extended priority layout, used bits
    typedef struct packed {
        logic port_match_priority;
        logic regulator_priority;
    } eid_prio_t;
endpackage

// File: verilog/eid_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------
module eid_sync #(
    parameter int W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_q; // First stage, read only by s2
    logic [W-1:0] s2_q; // Second stage
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            // Shift the pin through two flops
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    // Idle pull-up level, so no false edge follows reset
                    s1_q[b] <= 1'b1;
                    s2_q[b] <= 1'b1;
                end else begin
                    s1_q[b] <= i_async[b];
                    s2_q[b] <= s1_q[b];
                end
            end
        end
    endgenerate
    assign o_sync = s2_q;
endmodule // eid_sync
`default_nettype wire

// File: verilog/eid_detect.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Pin select, polarity and edge finder
// ----------------------------------------
module eid_detect #(
    parameter int NPINS = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [NPINS-1:0] i_pins,
    input wire logic [$clog2(NPINS)-1:0] i_sel,
    input wire logic i_pol,
    output logic o_active,
    output logic o_rise
);
    logic pin_w; // Selected pin level
    logic act_w; // Level after polarity
    logic prev_q; // Active level one cycle ago
    // Watch the chosen pin only, never drive it
    assign pin_w = i_pins[i_sel];
    // Polarity high keeps level, low inverts
    assign act_w = i_pol ? pin_w : ~pin_w;
    // Remember last active level
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= act_w;
        end
    end
    assign o_active = act_w;
    // Inactive to active transition
    assign o_rise = act_w & ~prev_q;
endmodule // eid_detect
`default_nettype wire

// File: verilog/eid_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "eid_regs.svh"
// ----------------------------------------
// External interrupt detect, top level
// ----------------------------------------
module eid_top #(
    parameter int NPINS = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire eid_pkg::eid_bus_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic [NPINS-1:0] i_port_pins,
    input wire logic [1:0] i_vector_ack,
    output logic [1:0] o_ext_pending,
    output logic o_port_match_hi,
    output logic o_regulator_hi,
    output logic o_irq
);
    import eid_pkg::*;

    localparam int SW = $clog2(NPINS);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    // Register state
    eid_prio_t prio_q; // Extended priority
    eid_prio_t prio_d;
    eid_cfg_t cfg_q; // Input configuration
    eid_cfg_t cfg_d;
    logic [1:0] trig_q; // Trigger type per input
    logic [1:0] trig_d;
    logic [1:0] pend_q; // Pending flags
    logic [1:0] pend_d;
    logic [1:0] stat_q; // Sticky event status
    logic [1:0] stat_d;
    logic [1:0] ien_q; // Event enables
    logic [1:0] ien_d;
    logic irq_q; // Interrupt output
    logic irq_d;
    logic [7:0] rdata_q; // Read data, one cycle
    logic [7:0] rdata_d;

    // Address decode
    logic wr_prio_w;
    logic wr_cfg_w;
    logic wr_timer_control_reg_w;
    logic wr_iclr_w;
    logic wr_ien_w;

    // Read views
    logic [7:0] prio_rd_w;
    logic [7:0] timer_control_reg_rd_w;
    logic [7:0] stat_rd_w;
    logic [7:0] ien_rd_w;
    logic [7:0] rd_mux_w;

    // Write data views
    logic [1:0] wr_trig_w;
    logic [1:0] wr_pend_w;
    logic [1:0] clr_mask_w;

    // Pin path
    logic [NPINS-1:0] pins_s; // Synchronised pins
    logic [SW-1:0] sel_w [2]; // Pin select per input
    logic [1:0] pol_w; // Polarity per input
    logic [1:0] act_w; // Active level per input
    logic [1:0] rise_w; // Rise per input

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign wr_prio_w = i_bus.wr && (i_bus.addr == `EID_OFS_PRIO);
    assign wr_cfg_w = i_bus.wr && (i_bus.addr == `EID_OFS_CFG);
    assign wr_timer_control_reg_w = i_bus.wr && (i_bus.addr == `EID_OFS_TIMER_CONTROL_REG);
    assign wr_iclr_w = i_bus.wr && (i_bus.addr == `EID_OFS_ICLR);
    assign wr_ien_w = i_bus.wr && (i_bus.addr == `EID_OFS_IEN);

    // Trigger type and pending fields of a write
    assign wr_trig_w = {i_bus.wdata[`EID_TIMER_CONTROL_REG_IT1], i_bus.wdata[`EID_TIMER_CONTROL_REG_IT0]};
    assign wr_pend_w = {i_bus.wdata[`EID_TIMER_CONTROL_REG_IE1], i_bus.wdata[`EID_TIMER_CONTROL_REG_IE0]};
    // Bits to clear in status
    assign clr_mask_w = wr_iclr_w ? i_bus.wdata[1:0] : 2'h0;

    // ----------------------------------------
    // Priority and configuration registers
    // ----------------------------------------
    // Only the two low bits are stored
    assign prio_d = wr_prio_w ? eid_prio_t'(i_bus.wdata[1:0]) : prio_q;
    // Pin select and polarity fields
    assign cfg_d = wr_cfg_w ? eid_cfg_t'(i_bus.wdata) : cfg_q;
    // Trigger type bits
    assign trig_d = wr_timer_control_reg_w ? wr_trig_w : trig_q;
    assign ien_d = wr_ien_w ? i_bus.wdata[1:0] : ien_q;

    // Hold the software registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prio_q <= eid_prio_t'(`EID_RST_PRIO);
            cfg_q <= eid_cfg_t'(`EID_RST_CFG);
            trig_q <= `EID_RST_TRIG;
            ien_q <= `EID_RST_IEN;
        end else begin
            prio_q <= prio_d;
            cfg_q <= cfg_d;
            trig_q <= trig_d;
            ien_q <= ien_d;
        end
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    eid_sync #(
        .W(NPINS)
    ) i_eid_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_port_pins),
        .o_sync(pins_s)
    );

    // Per-input select and polarity
    assign sel_w[0] = SW'(cfg_q.sel0);
    assign sel_w[1] = SW'(cfg_q.sel1);
    assign pol_w = {cfg_q.pol1, cfg_q.pol0};

    // ----------------------------------------
    // Per-input detection and pending flag
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            // Input only taps the pin level
            eid_detect #(
                .NPINS(NPINS)
            ) i_eid_detect (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_pins(pins_s),
                .i_sel(sel_w[ch]),
                .i_pol(pol_w[ch]),
                .o_active(act_w[ch]),
                .o_rise(rise_w[ch])
            );

            // Next pending value
            always_comb begin
                if (!trig_q[ch]) begin
                    // Level mode tracks the input
                    pend_d[ch] = act_w[ch];
                end else if (rise_w[ch]) begin
                    // Rise wins over any clear
                    pend_d[ch] = 1'b1;
                end else if (wr_timer_control_reg_w) begin
                    // Software write of the flag
                    pend_d[ch] = wr_pend_w[ch];
                end else if (i_vector_ack[ch]) begin
                    // Cleared when the CPU vectors
                    pend_d[ch] = 1'b0;
                end else begin
                    pend_d[ch] = pend_q[ch];
                end
            end

            // Sticky status; set wins over clear
            assign stat_d[ch] = rise_w[ch] | (stat_q[ch] & ~clr_mask_w[ch]);

            // ----------------------------------------
            // Per-input checks
            // ----------------------------------------
            // Level mode, high polarity, pin high
            property p_level_high;
                @(posedge i_clk_sys) disable iff (i_rst)
                (!trig_q[ch] && pol_w[ch] && pins_s[sel_w[ch]])
                |=> pend_q[ch];
            endproperty
            a_level_high: assert property (p_level_high)
                else $error("level high input did not set pending");

            // Level mode flag equals last active
            property p_level_follow;
                @(posedge i_clk_sys) disable iff (i_rst)
                !trig_q[ch] |=> (pend_q[ch] == $past(act_w[ch]));
            endproperty
            a_level_follow: assert property (p_level_follow)
                else $error("level pending does not follow input");

            // Selected pin drives the active level
            property p_sel_pin;
                @(posedge i_clk_sys) disable iff (i_rst)
                (act_w[ch] == (pins_s[sel_w[ch]] ~^ pol_w[ch]));
            endproperty
            a_sel_pin: assert property (p_sel_pin)
                else $error("active level not from selected pin");

            // Edge mode, two-cycle low then high
            property p_edge_set;
                @(posedge i_clk_sys) disable iff (i_rst)
                (trig_q[ch] && !act_w[ch]) ##1 (trig_q[ch] && act_w[ch])
                |=> pend_q[ch];
            endproperty
            a_edge_set: assert property (p_edge_set)
                else $error("edge did not set pending");

            // Edge mode, plain acknowledge clears
            property p_ack_clr;
                @(posedge i_clk_sys) disable iff (i_rst)
                (trig_q[ch] && i_vector_ack[ch] && !rise_w[ch] && !wr_timer_control_reg_w)
                |=> !pend_q[ch];
            endproperty
            a_ack_clr: assert property (p_ack_clr)
                else $error("vectoring did not clear pending");

            // Edge mode, no rise, no ack holds
            property p_edge_hold;
                @(posedge i_clk_sys) disable iff (i_rst)
                (trig_q[ch] && !rise_w[ch] && !i_vector_ack[ch] && !wr_timer_control_reg_w)
                |=> $stable(pend_q[ch]);
            endproperty
            a_edge_hold: assert property (p_edge_hold)
                else $error("edge pending changed without cause");
        end
    endgenerate

    // Hold pending, status and interrupt
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pend_q <= `EID_RST_PEND;
            stat_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    // Level interrupt while enabled status set
    assign irq_d = |(stat_q & ien_q);

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Upper six bits always zero
    assign prio_rd_w = {6'h00, prio_q};
    // Pending at bits 1 and 3, trigger at 0 and 2
    assign timer_control_reg_rd_w = {4'h0, pend_q[1], trig_q[1], pend_q[0], trig_q[0]};
    assign stat_rd_w = {6'h00, stat_q};
    assign ien_rd_w = {6'h00, ien_q};

    // Select by address, unmapped reads zero
    assign rd_mux_w = (i_bus.addr == `EID_OFS_PRIO) ? prio_rd_w :
                      (i_bus.addr == `EID_OFS_CFG) ? cfg_q :
                      (i_bus.addr == `EID_OFS_TIMER_CONTROL_REG) ? timer_control_reg_rd_w :
                      (i_bus.addr == `EID_OFS_ISTAT) ? stat_rd_w :
                      (i_bus.addr == `EID_OFS_IEN) ? ien_rd_w : 8'h00;
    // Data only in the cycle after a read
    assign rdata_d = i_bus.rd ? rd_mux_w : 8'h00;

    // Register the read data
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_rdata = rdata_q;
    assign o_ext_pending = pend_q;
    assign o_port_match_hi = prio_q.port_match_priority;
    assign o_regulator_hi = prio_q.regulator_priority;
    assign o_irq = irq_q;

    // ----------------------------------------
    // Top-level checks
    // ----------------------------------------
    // Priority read shows upper bits zero
    property p_prio_upper;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_bus.rd && i_bus.addr == `EID_OFS_PRIO) |=> (o_rdata[7:2] == 6'h00);
    endproperty
    a_prio_upper: assert property (p_prio_upper)
        else $error("priority upper bits not zero");

    // Port-match level follows written bit 1
    property p_pm_prio;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_prio_w |=> (o_port_match_hi == $past(i_bus.wdata[1]));
    endproperty
    a_pm_prio: assert property (p_pm_prio)
        else $error("port match priority not updated");

    // Regulator level follows written bit 0
    property p_reg_prio;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_prio_w |=> (o_regulator_hi == $past(i_bus.wdata[0]));
    endproperty
    a_reg_prio: assert property (p_reg_prio)
        else $error("regulator priority not updated");

    // Control read shows pending at bits 1, 3
    property p_timer_control_reg_rd;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_bus.rd && i_bus.addr == `EID_OFS_TIMER_CONTROL_REG)
        |=> (o_rdata[3] == $past(pend_q[1])) && (o_rdata[1] == $past(pend_q[0]));
    endproperty
    a_timer_control_reg_rd: assert property (p_timer_control_reg_rd)
        else $error("pending flags misplaced in control read");

    // Trigger bits sit at 0 and 2
    property p_trig_wr;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_timer_control_reg_w |=> (trig_q == {$past(i_bus.wdata[2]), $past(i_bus.wdata[0])});
    endproperty
    a_trig_wr: assert property (p_trig_wr)
        else $error("trigger type bits not stored");

    // Enabled status gives interrupt next cycle
    property p_irq;
        @(posedge i_clk_sys) disable iff (i_rst)
        ((stat_q & ien_q) != 2'h0) |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for enabled status");

    // Read data zero when no read before
    property p_rd_idle;
        @(posedge i_clk_sys) disable iff (i_rst)
        !i_bus.rd |=> (o_rdata == 8'h00);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
endmodule // eid_top
`default_nettype wire

// File: dv/eid_src_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// External sources on the port pins
// ----------------------------------------
module eid_src_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic [7:0] i_level,
    output logic [7:0] o_pins
);
    // Pin levels, idle high through pull-ups
    logic [7:0] pins_q;
    // Take a new level set on request, hold it until the next one
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pins_q <= 8'hFF;
        end else if (i_req) begin
            pins_q <= i_level;
        end
    end
    // Pins are inputs only; skipping them in the crossbar is software's task
    assign o_pins = pins_q;
endmodule // eid_src_model
`default_nettype wire

// File: dv/test_eid_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "eid_regs.svh"
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module test_eid_top;
    import eid_pkg::*;
    logic clk = 1'b0; // System clock
    logic rst = 1'b1; // Reset, active high
    eid_bus_t bus = '0; // Register bus request
    logic [1:0] ack = 2'h0; // Vector acknowledge
    logic req = 1'b0; // Source model request
    logic [7:0] lvl = 8'hFF; // Source model levels
    logic [7:0] pins; // Port pin levels
    logic [7:0] rdata; // Read data
    logic [1:0] pend; // Pending flags
    logic pm_hi; // Port-match priority
    logic reg_hi; // Regulator priority
    logic irq; // Interrupt line
    int bad_count = 0; // Mismatches
    int n_tests = 0; // Comparisons
    // ----------------------------------------
    // Clock, parts
    // ----------------------------------------
    always #4 clk = ~clk;
    eid_src_model i_eid_src_model (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_level(lvl), .o_pins(pins));
    eid_top #(.NPINS(8)) i_eid_top (.i_clk_sys(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
        .i_port_pins(pins), .i_vector_ack(ack), .o_ext_pending(pend), .o_port_match_hi(pm_hi),
        .o_regulator_hi(reg_hi), .o_irq(irq));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= {1'b1, 1'b0, a, d};
        @(posedge clk) bus <= '0;
    endtask
    // One-cycle read, data checked in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) bus <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk) bus <= '0;
        #1 check(rdata, exp);
    endtask
    // New pin levels, then time for sync and detect
    task automatic pins_to(input logic [7:0] v);
        @(posedge clk) begin
            req <= 1'b1;
            lvl <= v;
        end
        @(posedge clk) req <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
    endtask
    // One-cycle vector acknowledge
    task automatic vec(input logic [1:0] v);
        @(posedge clk) ack <= v;
        @(posedge clk) ack <= 2'h0;
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Values after reset, unmapped place
    task automatic t_reset;
        rd_chk(`EID_OFS_PRIO, 8'h00);
        rd_chk(`EID_OFS_CFG, 8'h01);
        rd_chk(`EID_OFS_TIMER_CONTROL_REG, 8'h00);
        rd_chk(`EID_OFS_IEN, 8'h00);
        // Idle pins must leave no false event after reset
        rd_chk(`EID_OFS_ISTAT, 8'h00);
        wr(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00);
        check({7'h00, irq}, 8'h00);
        check({6'h00, pend}, 8'h00);
    endtask
    // Priority bits, unused bits dropped
    task automatic t_prio;
        logic [7:0] wv [3];
        wv = '{8'hFF, 8'hFE, 8'hFD};
        for (int i = 0; i < 3; i++) begin
            wr(`EID_OFS_PRIO, wv[i]);
            @(posedge clk);
            #1 check({6'h00, pm_hi, reg_hi}, wv[i] & 8'h03);
            rd_chk(`EID_OFS_PRIO, wv[i] & 8'h03);
        end
    endtask
    // Level mode, flag follows the selected pin
    task automatic t_level(input logic pol);
        logic [7:0] idle;
        idle = pol ? 8'h00 : 8'hFF;
        pins_to(idle);
        wr(`EID_OFS_CFG, {pol, 3'h6, pol, 3'h3});
        wr(`EID_OFS_TIMER_CONTROL_REG, 8'h00);
        pins_to(idle);
        check({6'h00, pend}, 8'h00);
        // Pin 0 toggles too but is not selected
        pins_to(idle ^ 8'h09);
        check({6'h00, pend}, 8'h01);
        rd_chk(`EID_OFS_TIMER_CONTROL_REG, 8'h02);
        // Source still holding: acknowledge leaves the flag
        vec(2'h1);
        check({6'h00, pend}, 8'h01);
        pins_to(idle ^ 8'h49);
        check({6'h00, pend}, 8'h03);
        rd_chk(`EID_OFS_TIMER_CONTROL_REG, 8'h0A);
        pins_to(idle);
        check({6'h00, pend}, 8'h00);
    endtask
    // Edge mode, held until vectored
    task automatic t_edge(input logic pol);
        logic [7:0] idle;
        idle = pol ? 8'h00 : 8'hFF;
        pins_to(idle);
        wr(`EID_OFS_CFG, {pol, 3'h6, pol, 3'h3});
        wr(`EID_OFS_TIMER_CONTROL_REG, 8'h05);
        pins_to(idle);
        // Drop any flag left by the configuration change
        wr(`EID_OFS_TIMER_CONTROL_REG, 8'h05);
        pins_to(idle);
        check({6'h00, pend}, 8'h00);
        // Software sets both edge flags, then drops them again
        wr(`EID_OFS_TIMER_CONTROL_REG, 8'h0F);
        @(posedge clk);
        #1 check({6'h00, pend}, 8'h03);
        rd_chk(`EID_OFS_TIMER_CONTROL_REG, 8'h0F);
        wr(`EID_OFS_TIMER_CONTROL_REG, 8'h05);
        @(posedge clk);
        #1 check({6'h00, pend}, 8'h00);
        pins_to(idle ^ 8'h08);
        pins_to(idle);
        check({6'h00, pend}, 8'h01);
        rd_chk(`EID_OFS_TIMER_CONTROL_REG, 8'h07);
        vec(2'h1);
        check({6'h00, pend}, 8'h00);
        pins_to(idle ^ 8'h40);
        pins_to(idle);
        check({6'h00, pend}, 8'h02);
        vec(2'h2);
        check({6'h00, pend}, 8'h00);
    endtask
    // Status, clear, enable, interrupt line
    task automatic t_irq;
        wr(`EID_OFS_ICLR, 8'h03);
        rd_chk(`EID_OFS_ISTAT, 8'h00);
        wr(`EID_OFS_IEN, 8'h01);
        rd_chk(`EID_OFS_IEN, 8'h01);
        pins_to(8'h08);
        pins_to(8'h00);
        check({7'h00, irq}, 8'h01);
        pins_to(8'h40);
        pins_to(8'h00);
        rd_chk(`EID_OFS_ISTAT, 8'h03);
        // Bit 1 stays set but masked
        wr(`EID_OFS_ICLR, 8'h01);
        @(posedge clk);
        #1 check({7'h00, irq}, 8'h00);
        wr(`EID_OFS_ISTAT, 8'hFF);
        rd_chk(`EID_OFS_ISTAT, 8'h02);
        rd_chk(`EID_OFS_ICLR, 8'h00);
        wr(`EID_OFS_IEN, 8'h02);
        @(posedge clk);
        #1 check({7'h00, irq}, 8'h01);
        wr(`EID_OFS_ICLR, 8'h02);
        @(posedge clk);
        #1 check({7'h00, irq}, 8'h00);
    endtask
    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    // Print counts and verdict, then end
    task automatic report_and_stop;
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_prio;
        t_level(1'b0);
        t_level(1'b1);
        t_edge(1'b0);
        t_edge(1'b1);
        t_irq;
        report_and_stop;
    end
    // Watchdog, well beyond the expected run
    initial begin
        #200000;
        bad_count++;
        report_and_stop;
    end
endmodule // test_eid_top
`default_nettype wire
